// *** design/pll_clock_lowpower_break_ctl.v ***
// Purpose: Low-power and break behaviour of a crystal and PLL clock
//  generator, with its control bits behind an AXI4-Lite slave.
// Assumes: Wait, stop, break and lock levels come from other clock domains
//  and are synchronised here; the clock outputs are enables (1 = run).
// Notes: Fixed one-cycle bus answers; one write and one read at a time.
// Notes on behaviour
// - Wait leaves oscillator, PLL and base clock select as they were.
// - Lock-change interrupt of a powered PLL can wake wait.
// - Stop, no osc run option: oscillator and PLL off, outputs low.
// - Stop with VCO source clears base clock select; crystal takes over.
// - After stop, crystal half drives output; select stays clear.
// - Stop with osc run option: PLL off, outputs low; oscillator keeps running.
// - Break flag clear enable at one lets software clear flag in break.
// - Flag cleared during break stays cleared after break ends.
// - Enable at zero: break writes cannot clear the lock-change flag, except a write that turns auto mode off.
// - Auto mode: each lock change sets flag; interrupt only if enabled.
// - Auto mode off: no PLL interrupt, flag reads zero.
// - Select set: VCO half drives module clock; clear: crystal half.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_defines.vh"

module pll_clock_lowpower_break_ctl (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Core and integration module levels
	input wire wait_mode,
	input wire stop_mode,
	input wire break_state,
	input wire pll_lock_in,
	// Clock generator outputs
	output reg osc_enable,
	output reg pll_enable,
	output reg crystal_clock_out,
	output reg module_clock_out,
	output reg module_clock_from_vco,
	output reg pll_irq_out,
	output reg irq
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [3:0] sync1_reg;
	reg [3:0] sync2_reg;
	wire wait_s = sync2_reg[0];
	wire stop_s = sync2_reg[1];
	wire brk_s = sync2_reg[2];
	wire lock_s = sync2_reg[3];

	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
		end else begin
			sync1_reg <= {pll_lock_in, break_state, stop_mode, wait_mode};
			sync2_reg <= sync1_reg;
		end
	end

	// ----------------------------------------
	// Control state
	// ----------------------------------------
	reg pll_irq_enable_reg;
	reg pll_lock_change_flag_reg;
	reg pll_power_on_reg;
	reg base_clock_select_reg;
	reg auto_bw_reg;
	reg osc_run_in_stop_reg;
	reg break_flag_clear_enable_reg;
	// Reset image of the control register, split into its bits below
	localparam [7:0] CTL_RST = `RST_PLL_CONTROL;
	reg [`EV_WIDTH-1:0] mask_reg;
	reg lock_prev_reg;
	reg stop_prev_reg;

	// Lock only has meaning in auto mode with the PLL powered
	wire lock_eff = lock_s & auto_bw_reg & pll_power_on_reg & ~stop_s;
	wire lock_changed = auto_bw_reg & (lock_eff ^ lock_prev_reg);
	wire stop_rise = stop_s & ~stop_prev_reg;
	wire stop_fall = ~stop_s & stop_prev_reg;

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	reg aw_held_reg;
	reg [3:0] aw_addr_reg;
	reg w_held_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;

	wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	wire wr_lane0 = do_write & w_strb_reg[0];
	wire wr_ctl = wr_lane0 & (aw_addr_reg == `OFS_PLL_CONTROL);
	wire wr_bfc = wr_lane0 & (aw_addr_reg == `OFS_BREAK_FLAG_CONTROL);
	wire wr_sts = wr_lane0 & (aw_addr_reg == `OFS_IRQ_STATUS);
	wire wr_msk = wr_lane0 & (aw_addr_reg == `OFS_IRQ_MASK);
	wire wr_known = (aw_addr_reg == `OFS_PLL_CONTROL) |
		(aw_addr_reg == `OFS_BREAK_FLAG_CONTROL) |
		(aw_addr_reg == `OFS_IRQ_STATUS) |
		(aw_addr_reg == `OFS_IRQ_MASK);
	// Break protection of the flag clear
	wire flag_clear_ok = ~brk_s | break_flag_clear_enable_reg;
	wire flag_clear = wr_ctl & ~w_data_reg[`BIT_LOCK_CHANGE_FLAG] &
		flag_clear_ok;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Control bits, flag and stop handling
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			pll_irq_enable_reg <= CTL_RST[`BIT_PLL_IRQ_ENABLE];
			pll_lock_change_flag_reg <= CTL_RST[`BIT_LOCK_CHANGE_FLAG];
			pll_power_on_reg <= CTL_RST[`BIT_PLL_POWER_ON];
			base_clock_select_reg <= CTL_RST[`BIT_BASE_CLOCK_SELECT];
			auto_bw_reg <= CTL_RST[`BIT_AUTO_BANDWIDTH];
			osc_run_in_stop_reg <= CTL_RST[`BIT_OSC_RUN_IN_STOP];
			break_flag_clear_enable_reg <= `RST_BREAK_FLAG_CONTROL;
			mask_reg <= `RST_IRQ_MASK;
			lock_prev_reg <= 1'b0;
			stop_prev_reg <= 1'b0;
		end else begin
			lock_prev_reg <= lock_eff;
			stop_prev_reg <= stop_s;
			// Wait is not looked at: config stays as software left it
			if (wr_ctl) begin
				pll_irq_enable_reg <= w_data_reg[`BIT_PLL_IRQ_ENABLE];
				pll_power_on_reg <= w_data_reg[`BIT_PLL_POWER_ON];
				base_clock_select_reg <= w_data_reg[`BIT_BASE_CLOCK_SELECT];
				auto_bw_reg <= w_data_reg[`BIT_AUTO_BANDWIDTH];
				osc_run_in_stop_reg <= w_data_reg[`BIT_OSC_RUN_IN_STOP];
			end
			// Stop forces the crystal source; stays clear afterwards
			if (stop_s)
				base_clock_select_reg <= 1'b0;
			if (wr_bfc)
				break_flag_clear_enable_reg <=
					w_data_reg[`BIT_BREAK_FLAG_CLEAR_ENABLE];
			if (wr_msk)
				mask_reg <= w_data_reg[`EV_WIDTH-1:0];
			// Auto mode off clears; otherwise set wins over clear, and a later lock change sets it again
			if (!auto_bw_reg)
				pll_lock_change_flag_reg <= 1'b0;
			else if (lock_changed)
				pll_lock_change_flag_reg <= 1'b1;
			else if (flag_clear)
				pll_lock_change_flag_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Sticky status bits, one per event
	// ----------------------------------------
	wire [`EV_WIDTH-1:0] ev_set = {stop_fall, stop_rise, lock_changed};
	wire [`EV_WIDTH-1:0] ev_clr = wr_sts ? w_data_reg[`EV_WIDTH-1:0] :
		{`EV_WIDTH{1'b0}};
	wire [`EV_WIDTH-1:0] status_bits;
	genvar gi;

	generate
		for (gi = 0; gi < `EV_WIDTH; gi = gi + 1) begin : g_status
			reg sticky_reg;
			// Set wins, so an event in the clearing cycle is not lost
			always @(posedge aclk) begin
				if (!aresetn) begin
					sticky_reg <= 1'b0;
				end else if (ev_set[gi]) begin
					sticky_reg <= 1'b1;
				end else if (ev_clr[gi]) begin
					sticky_reg <= 1'b0;
				end
			end
			assign status_bits[gi] = sticky_reg;
		end
	endgenerate

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			osc_enable <= 1'b0;
			pll_enable <= 1'b0;
			crystal_clock_out <= 1'b0;
			module_clock_out <= 1'b0;
			module_clock_from_vco <= 1'b0;
			pll_irq_out <= 1'b0;
			irq <= 1'b0;
		end else begin
			osc_enable <= ~stop_s | osc_run_in_stop_reg;
			pll_enable <= pll_power_on_reg & ~stop_s;
			crystal_clock_out <= ~stop_s;
			module_clock_out <= ~stop_s;
			module_clock_from_vco <= base_clock_select_reg & ~stop_s;
			// Works in wait too, so a lock change can wake the core
			pll_irq_out <= ~stop_s & auto_bw_reg & pll_irq_enable_reg &
				pll_lock_change_flag_reg;
			irq <= |(status_bits & mask_reg);
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case ({s_axi_araddr[3:2], 2'b00})
				`OFS_PLL_CONTROL: begin
					s_axi_rdata <= {24'h0, pll_irq_enable_reg,
						pll_lock_change_flag_reg & auto_bw_reg,
						pll_power_on_reg, base_clock_select_reg, auto_bw_reg,
						osc_run_in_stop_reg, lock_eff, 1'b0};
				end
				`OFS_BREAK_FLAG_CONTROL: begin
					s_axi_rdata <= {31'h0, break_flag_clear_enable_reg};
				end
				`OFS_IRQ_STATUS: begin
					s_axi_rdata <= {29'h0, status_bits};
				end
				`OFS_IRQ_MASK: begin
					s_axi_rdata <= {29'h0, mask_reg};
				end
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// *** design/clkgen_defines.vh ***
// Purpose: Constants for the clock generator low-power and break control.
// Assumes: 32-bit AXI4-Lite register bus, word aligned.
// Notes: Offsets are byte addresses.
`ifndef CLKGEN_DEFINES_VH
`define CLKGEN_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_PLL_CONTROL 4'h0
`define OFS_BREAK_FLAG_CONTROL 4'h4
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_MASK 4'hc

// ----------------------------------------
// Field positions of the PLL control register
// ----------------------------------------
`define BIT_PLL_IRQ_ENABLE 7
`define BIT_LOCK_CHANGE_FLAG 6
`define BIT_PLL_POWER_ON 5
`define BIT_BASE_CLOCK_SELECT 4
`define BIT_AUTO_BANDWIDTH 3
`define BIT_OSC_RUN_IN_STOP 2
`define BIT_LOCK 1

// ----------------------------------------
// Other fields and status events
// ----------------------------------------
`define BIT_BREAK_FLAG_CLEAR_ENABLE 0
`define EV_LOCK_CHANGE 0
`define EV_STOP_ENTRY 1
`define EV_STOP_EXIT 2
`define EV_WIDTH 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PLL_CONTROL 8'h20
`define RST_BREAK_FLAG_CONTROL 1'b0
`define RST_IRQ_MASK 3'h0

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** verification/clk_ctl_chk.sv ***
// Purpose: Port checks for the clock control block.
// Assumes: Core levels reach the outputs on the third edge.
// Notes: Bound to the design at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module clk_ctl_chk (
	// Clock and bus
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_bvalid,
	// Core levels
	input wire logic wait_mode,
	input wire logic stop_mode,
	// Generator outputs
	input wire logic osc_enable,
	input wire logic pll_enable,
	input wire logic crystal_clock_out,
	input wire logic module_clock_out,
	input wire logic module_clock_from_vco,
	input wire logic pll_irq_out,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Four samples cover the sync stages
	sequence in_stop; stop_mode [*4]; endsequence
	sequence quiet; (!stop_mode && !s_axi_awvalid) [*4]; endsequence
	stop_off_a: assert property (
		in_stop |-> !pll_enable && !crystal_clock_out && !module_clock_out
		&& !pll_irq_out) else $error("generator alive in stop");
	stop_sel_a: assert property (
		in_stop |-> !module_clock_from_vco) else $error("vco kept in stop");
	osc_fall_a: assert property (
		$fell(osc_enable) |-> $past(stop_mode, 3)) else $error("osc dropped");
	exit_src_a: assert property (
		$rose(module_clock_out) |-> !module_clock_from_vco)
		else $error("restart on vco");
	exit_run_a: assert property (
		$fell(stop_mode) |-> ##[2:4] (crystal_clock_out && module_clock_out))
		else $error("no restart");
	wait_keep_a: assert property (
		quiet ##0 $rose(wait_mode) |=> ($stable(osc_enable)
		&& $stable(pll_enable) && $stable(module_clock_from_vco)) [*2])
		else $error("wait changed generator");
	sel_rise_a: assert property (
		$rose(module_clock_from_vco) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("vco select without write");
	reset_quiet_a: assert property (
		$rose(aresetn) |-> !pll_irq_out && !irq) else $error("irq at reset");
endmodule
bind pll_clock_lowpower_break_ctl clk_ctl_chk chk_u (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_bvalid(s_axi_bvalid), .wait_mode(wait_mode),
	.stop_mode(stop_mode), .osc_enable(osc_enable), .pll_enable(pll_enable),
	.crystal_clock_out(crystal_clock_out), .irq(irq),
	.module_clock_out(module_clock_out), .pll_irq_out(pll_irq_out),
	.module_clock_from_vco(module_clock_from_vco));
`default_nettype wire

// *** verification/core_side_model.sv ***
// Purpose: Core and integration module levels.
// Assumes: Levels change just after an edge.
// Notes: The lock level stands in for the analog detector.
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
	// Clock
	input wire logic aclk,
	// Wait, stop, break and lock levels
	output wire logic wait_mode,
	output wire logic stop_mode,
	output wire logic break_state,
	output wire logic pll_lock_in
);
	logic [3:0] lv = 4'h0;
	assign {wait_mode, stop_mode, break_state, pll_lock_in} = lv;
	// Held until the next call, never glitched mid-cycle
	task automatic drive(input logic [3:0] v);
		@(posedge aclk);
		lv <= v;
	endtask
endmodule
`default_nettype wire

// *** verification/tb_pll_clock_lowpower_break_ctl.sv ***
// Purpose: Register and low-power tests of the clock control block.
// Assumes: Bus answers come when they come; only the watchdog ends a wait.
// Notes: Outputs are packed osc,pll,xclk,mclk,vco,pll_irq,irq.
`timescale 1ns/1ps
`default_nettype none
module tb_pll_clock_lowpower_break_ctl;
	logic aclk = 1'b0;
	logic aresetn;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata;
	logic awvalid, wvalid, bready, arvalid, rready;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire awready, wready, bvalid, arready, rvalid, wt, st, brk, lk;
	wire osc, pll, xc, mc, vco, pirq, irq;
	wire [6:0] outs = {osc, pll, xc, mc, vco, pirq, irq};
	int err_total = 0;
	int checks = 0;
	always #25 aclk = ~aclk;
	core_side_model core_u (.aclk(aclk), .wait_mode(wt), .stop_mode(st),
		.break_state(brk), .pll_lock_in(lk));
	pll_clock_lowpower_break_ctl dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .wait_mode(wt), .stop_mode(st),
		.break_state(brk), .pll_lock_in(lk), .osc_enable(osc),
		.pll_enable(pll), .crystal_clock_out(xc), .module_clock_out(mc),
		.module_clock_from_vco(vco), .pll_irq_out(pirq), .irq(irq));
	task automatic chk(input string s, input logic [31:0] seen, e);
		checks++;
		if (seen !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", s, e, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, bresp}, 32'h0);
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] e, input string s);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk(s, rdata, e);
		chk("rresp", {30'h0, rresp}, 32'h0);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Hang guard, far beyond the few hundred cycles used
	initial begin
		#1000000;
		err_total++;
		tally_and_finish();
	end
	// ----
	// Tests
	// ----
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h0;
		{awaddr, araddr, wstrb, wdata} <= {12'h00f, 32'h0};
		cyc(4);
		aresetn <= 1'b1;
		core_u.drive(4'b0001);
		cyc(6);
		rc(4'h0, 32'h20, "ctl");
		rc(4'h4, 32'h0, "break_flag_clear_enable");
		rc(4'hc, 32'h0, "mask");
		wstrb <= 4'he;
		wr(4'h0, 32'h0);
		wstrb <= 4'hf;
		rc(4'h0, 32'h20, "ctl strobe");
		chk("outs", outs, 7'b1111000);
		$display("reset test done");
		wr(4'h0, 32'h28);
		cyc(6);
		rc(4'h0, 32'h6a, "ctl");
		rc(4'h8, 32'h1, "status");
		wr(4'hc, 32'h1);
		wr(4'h0, 32'he8);
		cyc(3);
		chk("outs", outs, 7'b1111011);
		wr(4'h0, 32'hf8);
		cyc(3);
		chk("outs", outs, 7'b1111111);
		wr(4'h0, 32'hb8);
		wr(4'h8, 32'h1);
		cyc(4);
		$display("lock test done");
		wr(4'h0, 32'ha8);
		core_u.drive(4'b1001);
		core_u.drive(4'b1000);
		cyc(8);
		chk("outs", outs, 7'b1111011);
		core_u.drive(4'b0010);
		cyc(4);
		$display("wait test done");
		wr(4'h0, 32'hb8);
		rc(4'h0, 32'hf8, "ctl");
		wr(4'h4, 32'h1);
		wr(4'h0, 32'hb8);
		rc(4'h0, 32'hb8, "ctl");
		core_u.drive(4'b0000);
		cyc(4);
		rc(4'h0, 32'hb8, "ctl");
		wr(4'h8, 32'h7);
		$display("break test done");
		core_u.drive(4'b0100);
		cyc(6);
		chk("outs", outs, 7'b0000000);
		core_u.drive(4'b0000);
		cyc(6);
		rc(4'h0, 32'ha8, "ctl");
		chk("outs", outs, 7'b1111000);
		rc(4'h8, 32'h6, "status");
		wr(4'h0, 32'hac);
		core_u.drive(4'b0100);
		cyc(6);
		chk("outs", outs, 7'b1000000);
		core_u.drive(4'b0000);
		cyc(6);
		$display("stop test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
